// file: core/kkds_pkg.sv
// package: register map, reset values, key codes and carrier types for the keypad block
package kkds_pkg;
  // register byte offsets on the apb bus
  localparam logic [11:0] KKDS_OFF_MF_SEL = 12'h000;
  localparam logic [11:0] KKDS_OFF_STOP_SCOPE = 12'h004;
  localparam logic [11:0] KKDS_OFF_RUN_MASK1 = 12'h008;
  localparam logic [11:0] KKDS_OFF_RUN_MASK2 = 12'h00C;
  localparam logic [11:0] KKDS_OFF_STOP_MASK = 12'h010;
  localparam logic [11:0] KKDS_OFF_STATUS = 12'h014;
  // values after reset
  localparam logic [15:0] KKDS_RST_MF_SEL = 16'h0000;
  localparam logic [15:0] KKDS_RST_STOP_SCOPE = 16'h0001;
  localparam logic [15:0] KKDS_RST_RUN_MASK1 = 16'h001F;
  localparam logic [15:0] KKDS_RST_RUN_MASK2 = 16'h0000;
  localparam logic [15:0] KKDS_RST_STOP_MASK = 16'h0003;
  // multi-function key codes
  localparam logic [15:0] KKDS_MF_NONE = 16'h0000;
  localparam logic [15:0] KKDS_MF_CHAN = 16'h0001;
  localparam logic [15:0] KKDS_MF_DIR = 16'h0002;
  localparam logic [15:0] KKDS_MF_JOG_FWD = 16'h0003;
  localparam logic [15:0] KKDS_MF_JOG_REV = 16'h0004;
  localparam logic [15:0] KKDS_MF_PID = 16'h0005;
  // stop key scope codes
  localparam logic [15:0] KKDS_SCOPE_PANEL = 16'h0000;
  localparam logic [15:0] KKDS_SCOPE_ANY = 16'h0001;
  // stopped view: bit 3 and bits 13..15 select nothing
  localparam logic [15:0] KKDS_STOP_VALID = 16'h1FF7;
  // key actions toward the drive
  typedef struct packed {
    logic cmd_src_toggle;
    logic dir_toggle;
    logic jog_fwd;
    logic jog_rev;
    logic pid_panel_valid;
    logic halt_req;
    logic cmd_remote;
    logic dir_reverse;
  } kkds_key_out_t;
  // display selection toward the panel
  typedef struct packed {
    logic valid;
    logic run_view;
    logic [4:0] item;
  } kkds_disp_t;
endpackage : kkds_pkg

// file: core/kkds_key_decode.sv
// key decode: multi-function key and halt/clear key actions
`timescale 1ns/1ns
module kkds_key_decode
  import kkds_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mf_lvl,
  input wire logic halt_lvl,
  input wire logic [15:0] mf_sel,
  input wire logic [15:0] stop_scope,
  input wire logic panel_active,
  output kkds_key_out_t key_out
);
  typedef struct packed {
    logic mf_prev;
    logic halt_prev;
    kkds_key_out_t o;
  } kkds_kd_st_t;
  kkds_kd_st_t st_q, st_d;
  logic mf_press;
  logic halt_press;

  // press edges, actions decoded from the selection codes
  always_comb
  begin
    mf_press = mf_lvl & ~st_q.mf_prev;
    halt_press = halt_lvl & ~st_q.halt_prev;
    st_d = st_q;
    st_d.mf_prev = mf_lvl;
    st_d.halt_prev = halt_lvl;
    st_d.o.cmd_src_toggle = mf_press && (mf_sel == KKDS_MF_CHAN);
    st_d.o.dir_toggle = mf_press && (mf_sel == KKDS_MF_DIR);
    st_d.o.jog_fwd = mf_lvl && (mf_sel == KKDS_MF_JOG_FWD);
    st_d.o.jog_rev = mf_lvl && (mf_sel == KKDS_MF_JOG_REV);
    st_d.o.pid_panel_valid = (mf_sel == KKDS_MF_PID);
    if (st_d.o.cmd_src_toggle)
      st_d.o.cmd_remote = ~st_q.o.cmd_remote;
    if (st_d.o.dir_toggle)
      st_d.o.dir_reverse = ~st_q.o.dir_reverse;
    // halt only from panel unless scope covers all channels
    st_d.o.halt_req = halt_press && ((stop_scope == KKDS_SCOPE_ANY)
      || (stop_scope == KKDS_SCOPE_PANEL && panel_active));
  end

  // state register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign key_out = st_q.o;
endmodule : kkds_key_decode

// file: core/kkds_disp_step.sv
// display stepper: walks enabled items of the active mask upward
`timescale 1ns/1ns
module kkds_disp_step
  import kkds_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic step_lvl,
  input wire logic running,
  input wire logic [15:0] run_mask1,
  input wire logic [15:0] run_mask2,
  input wire logic [15:0] stop_mask,
  output kkds_disp_t disp
);
  typedef struct packed {
    logic step_prev;
    kkds_disp_t o;
  } kkds_ds_st_t;
  kkds_ds_st_t st_q, st_d;
  logic [31:0] act_mask;

  // next set bit strictly after cur, wrapping round
  function automatic logic [4:0] kkds_next(input logic [31:0] m, input logic [4:0] cur);
    logic [4:0] r;
    logic found;
    logic [4:0] j;
    r = cur;
    found = 1'b0;
    for (int i = 1; i <= 32; i++)
    begin
      j = cur + 5'(i);
      if (!found && m[j])
      begin
        r = j;
        found = 1'b1;
      end
    end
    return r;
  endfunction : kkds_next

  // pick mask by run state, restart on view change or lost item
  always_comb
  begin
    act_mask = running ? {run_mask2, run_mask1}
      : {16'h0000, stop_mask & KKDS_STOP_VALID};
    st_d = st_q;
    st_d.step_prev = step_lvl;
    st_d.o.valid = |act_mask;
    st_d.o.run_view = running;
    if (running != st_q.o.run_view || !act_mask[st_q.o.item])
      st_d.o.item = kkds_next(act_mask, 5'h1F);
    else if (step_lvl && !st_q.step_prev)
      st_d.o.item = kkds_next(act_mask, st_q.o.item);
  end

  // state register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign disp = st_q.o;
endmodule : kkds_disp_step

// file: core/kkds_top.sv
// top: apb register file, key synchronisers, key decode and display stepping
// Operation
// - code 0 key does nothing; code 1 toggles panel/remote command source per press
// - code 2 toggles direction, 3 forward jog, 4 reverse jog, 5 panel pid valid
// - stop scope 0: halt key stops drive only when panel is the channel
// - stop scope 1, the default: halt key stops drive from any channel
// - run mask one bits 0-7: frequencies, voltages, current, power, torque, inputs
// - run mask one bits 8-15: outputs, analogs, count, length, speed, pid; resets 1F
// - run mask two bits 0-7: pid feedback, stage, pulse khz, timers, raw analogs
// - run mask two bits 8-15: speeds, hours, pulse hz, comms, encoder, main, aux
// - stop mask bits 0-2 and 4-7 select items; bit 3 selects nothing
// - stop mask bits 8-12 select items; mask resets to 03
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module kkds_top
  import kkds_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic multi_function_key,
  input wire logic halt_clear_key,
  input wire logic display_step_key,
  input wire logic drive_running,
  input wire logic panel_channel_active,
  output kkds_key_out_t key_out,
  output kkds_disp_t disp
);
  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [15:0] mf_sel;
    logic [15:0] stop_scope;
    logic [15:0] run_mask1;
    logic [15:0] run_mask2;
    logic [15:0] stop_mask;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } kkds_top_st_t;
  kkds_top_st_t st_q, st_d;
  logic acc_start;
  logic acc_done;
  logic hit;
  logic [31:0] rd_word;

  // address decode and read mux
  always_comb
  begin
    hit = 1'b1;
    rd_word = 32'h00000000;
    unique case (paddr)
      KKDS_OFF_MF_SEL: rd_word = {16'h0000, st_q.mf_sel};
      KKDS_OFF_STOP_SCOPE: rd_word = {16'h0000, st_q.stop_scope};
      KKDS_OFF_RUN_MASK1: rd_word = {16'h0000, st_q.run_mask1};
      KKDS_OFF_RUN_MASK2: rd_word = {16'h0000, st_q.run_mask2};
      KKDS_OFF_STOP_MASK: rd_word = {16'h0000, st_q.stop_mask};
      KKDS_OFF_STATUS: rd_word = {22'h000000, key_out.cmd_remote, key_out.dir_reverse,
        disp.valid, disp.run_view, 1'b0, disp.item};
      default: hit = 1'b0;
    endcase
  end

  // apb slave: one wait state, write at completing edge
  always_comb
  begin
    acc_start = psel && penable && !st_q.pready;
    acc_done = psel && penable && st_q.pready;
    st_d = st_q;
    st_d.sync1 = {display_step_key, halt_clear_key, multi_function_key};
    st_d.sync2 = st_q.sync1;
    st_d.pready = acc_start;
    st_d.pslverr = acc_start && (!hit || (pwrite && paddr == KKDS_OFF_STATUS));
    st_d.prdata = (acc_start && !pwrite) ? rd_word : 32'h00000000;
    if (acc_done && pwrite)
    begin
      unique case (paddr)
        KKDS_OFF_MF_SEL: st_d.mf_sel = pwdata[15:0];
        KKDS_OFF_STOP_SCOPE: st_d.stop_scope = pwdata[15:0];
        KKDS_OFF_RUN_MASK1: st_d.run_mask1 = pwdata[15:0];
        KKDS_OFF_RUN_MASK2: st_d.run_mask2 = pwdata[15:0];
        KKDS_OFF_STOP_MASK: st_d.stop_mask = pwdata[15:0];
        default: st_d.stop_mask = st_q.stop_mask;
      endcase
    end
  end

  // state register with documented reset values
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_q <= '0;
      st_q.mf_sel <= KKDS_RST_MF_SEL;
      st_q.stop_scope <= KKDS_RST_STOP_SCOPE;
      st_q.run_mask1 <= KKDS_RST_RUN_MASK1;
      st_q.run_mask2 <= KKDS_RST_RUN_MASK2;
      st_q.stop_mask <= KKDS_RST_STOP_MASK;
    end
    else
      st_q <= st_d;
  end

  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign prdata = st_q.prdata;

  // key actions
  kkds_key_decode u_key
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .mf_lvl(st_q.sync2[0]),
    .halt_lvl(st_q.sync2[1]),
    .mf_sel(st_q.mf_sel),
    .stop_scope(st_q.stop_scope),
    .panel_active(panel_channel_active),
    .key_out(key_out)
  );

  // display item selection
  kkds_disp_step u_disp
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .step_lvl(st_q.sync2[2]),
    .running(drive_running),
    .run_mask1(st_q.run_mask1),
    .run_mask2(st_q.run_mask2),
    .stop_mask(st_q.stop_mask),
    .disp(disp)
  );

  // checks on the block's own outputs
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  logic mf_l;
  logic halt_l;
  logic step_l;
  logic [31:0] act_view;
  assign mf_l = st_q.sync2[0];
  assign halt_l = st_q.sync2[1];
  assign step_l = st_q.sync2[2];
  assign act_view = disp.run_view ? {st_q.run_mask2, st_q.run_mask1}
    : {16'h0000, st_q.stop_mask & KKDS_STOP_VALID};

  mf_idle_a: assert property ($rose(mf_l) && st_q.mf_sel == KKDS_MF_NONE
    |=> !key_out.cmd_src_toggle && !key_out.dir_toggle && !key_out.jog_fwd
      && !key_out.jog_rev)
    else $error("code 0 key press had an effect");
  chan_toggle_a: assert property ($rose(mf_l) && st_q.mf_sel == KKDS_MF_CHAN
    |=> key_out.cmd_src_toggle && key_out.cmd_remote != $past(key_out.cmd_remote))
    else $error("channel toggle missing");
  dir_toggle_a: assert property ($rose(mf_l) && st_q.mf_sel == KKDS_MF_DIR
    |=> key_out.dir_toggle ##1 !key_out.dir_toggle)
    else $error("direction toggle not a single pulse");
  jog_hold_a: assert property (mf_l && st_q.mf_sel == KKDS_MF_JOG_FWD
    |=> key_out.jog_fwd && !key_out.jog_rev)
    else $error("forward jog not held");
  pid_valid_a: assert property ($stable(st_q.mf_sel)
    |-> key_out.pid_panel_valid == ($past(st_q.mf_sel) == KKDS_MF_PID))
    else $error("pid valid mismatch");
  halt_panel_a: assert property ($rose(halt_l) && st_q.stop_scope == KKDS_SCOPE_PANEL
    |=> key_out.halt_req == $past(panel_channel_active))
    else $error("panel-only halt wrong");
  halt_any_a: assert property ($rose(halt_l) && st_q.stop_scope == KKDS_SCOPE_ANY
    |=> key_out.halt_req)
    else $error("halt from any channel missing");
  reset_masks_a: assert property ($past(rst)
    |-> st_q.run_mask1 == KKDS_RST_RUN_MASK1 && st_q.stop_mask == KKDS_RST_STOP_MASK
      && st_q.stop_scope == KKDS_RST_STOP_SCOPE)
    else $error("reset values wrong");
  item_enabled_a: assert property ($stable(act_view) && $stable(drive_running)
    && disp.run_view == drive_running ##1 $stable(act_view) |-> act_view[disp.item]
      || !disp.valid)
    else $error("shown item not enabled");
  stop_bit3_a: assert property (disp.valid && !disp.run_view && $stable(disp.run_view)
    ##1 $stable(disp.run_view) |-> disp.item != 5'h03 && disp.item < 5'h0D)
    else $error("stopped view shows undefined item");
  step_up_a: assert property ($rose(step_l) && $countones(act_view) > 1
    && $stable(act_view) && disp.run_view == drive_running && act_view[disp.item]
    |=> disp.item != $past(disp.item))
    else $error("step did not advance");
  view_sel_a: assert property ($changed(drive_running) |=> disp.run_view == drive_running)
    else $error("view does not follow run state");

  cv_chan_c: cover property ($rose(mf_l) && st_q.mf_sel == KKDS_MF_CHAN ##1
    key_out.cmd_src_toggle);
  cv_halt_c: cover property (key_out.halt_req && !panel_channel_active);
  cv_wrap_c: cover property ($rose(step_l) ##1 disp.item < $past(disp.item));
  cv_write_c: cover property (psel && penable && pready && pwrite);
endmodule : kkds_top

// file: verification/kkds_operator.sv
// operator model: presses and releases the three panel keys
`timescale 1ns/1ns
module kkds_operator
(
  input wire logic clk_sys,
  output logic mf_key,
  output logic halt_key,
  output logic step_key
);
  // keys rest released
  initial
  begin
    mf_key = 1'b0;
    halt_key = 1'b0;
    step_key = 1'b0;
  end
  // one press: hold the key, release, let the panel settle
  task automatic press(input int which, input int hold);
    if (which == 0) mf_key <= 1'b1;
    else if (which == 1) halt_key <= 1'b1;
    else step_key <= 1'b1;
    repeat (hold) @(posedge clk_sys);
    mf_key <= 1'b0;
    halt_key <= 1'b0;
    step_key <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask : press
endmodule : kkds_operator

// file: verification/test_keypad_key_display_select.sv
// self-checking bench for the keypad key and display select block
`timescale 1ns/1ns
module test_keypad_key_display_select
  import kkds_pkg::*;
;
  logic clk_sys, rst, psel, penable, pwrite, drive_running, panel_channel_active, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr;
  wire mf, halt, step;
  kkds_key_out_t key_out;
  kkds_disp_t disp;
  int error_cnt, samples_checked, halt_cnt, cur, e_rem, e_dir;
  int rm[5] = '{0, 1, 31, 0, 3};
  kkds_top dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .multi_function_key(mf), .halt_clear_key(halt),
    .display_step_key(step), .drive_running(drive_running),
    .panel_channel_active(panel_channel_active), .key_out(key_out), .disp(disp));
  kkds_operator op_u (.clk_sys(clk_sys), .mf_key(mf), .halt_key(halt), .step_key(step));
  // clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // count halt pulses
  always @(posedge clk_sys)
    if (key_out.halt_req === 1'b1) halt_cnt++;
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    // hold the request until pready is seen high at a rising edge
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic wr_reg(input int i, input logic [31:0] wd);
    rm[i] = wd[15:0];
    apb(1'b1, 12'(i * 4), wd);
  endtask : wr_reg
  // model: active mask, run view is both run masks, stop view only valid bits
  function automatic int act_mask();
    if (drive_running) return (rm[3] << 16) | rm[2];
    return rm[4] & 32'h1FF7;
  endfunction : act_mask
  // model: next enabled index above c with wrap; c of -1 gives the lowest
  function automatic int nxt(input int m, input int c);
    for (int i = 1; i <= 32; i++)
      if (m[(c + i) % 32]) return (c + i) % 32;
    return c;
  endfunction : nxt
  task automatic chk_disp();
    chk("disp valid", disp.valid, act_mask() != 0);
    chk("disp item", disp.item, cur);
    chk("disp view", disp.run_view, drive_running);
  endtask : chk_disp
  task automatic steps(input int n);
    for (int k = 0; k < n; k++)
    begin
      op_u.press(2, 4);
      cur = nxt(act_mask(), cur);
      chk_disp();
    end
  endtask : steps
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    results();
  end
  // main sequence
  initial
  begin
    void'($urandom(32'h53EB255F));
    {rst, psel, penable, pwrite, drive_running, panel_channel_active} = 6'h20;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk("reset reg", rd, rm[i]);
    end
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped err", er, 1);
    apb(1'b0, 12'h014, 32'h0);
    chk("status", rd, 32'h80);
    $display("test registers done");
    cur = 0;
    chk_disp();
    steps(3);
    wr_reg(4, $urandom | 32'hFFFF);
    if (!act_mask()[cur]) cur = nxt(act_mask(), -1);
    steps(15);
    $display("test stop view done");
    wr_reg(2, $urandom | 32'h1);
    wr_reg(3, $urandom);
    apb(1'b0, 12'h008, 32'h0);
    chk("run mask one", rd, rm[2]);
    apb(1'b0, 12'h00C, 32'h0);
    chk("run mask two", rd, rm[3]);
    drive_running <= 1'b1;
    repeat (3) @(posedge clk_sys);
    cur = nxt(act_mask(), -1);
    chk_disp();
    steps(34);
    $display("test run view done");
    for (int c = 0; c < 7; c++)
    begin
      wr_reg(0, c);
      fork
        op_u.press(0, 10);
        begin
          repeat (6) @(posedge clk_sys);
          #1;
          chk("jog fwd", key_out.jog_fwd, c == 3);
          chk("jog rev", key_out.jog_rev, c == 4);
        end
      join
      e_rem ^= (c == 1);
      e_dir ^= (c == 2);
      chk("cmd remote", key_out.cmd_remote, e_rem);
      chk("dir reverse", key_out.dir_reverse, e_dir);
      chk("pid valid", key_out.pid_panel_valid, c == 5);
    end
    $display("test function key done");
    for (int s = 0; s < 4; s++)
    begin
      wr_reg(1, s / 2);
      panel_channel_active <= s[0];
      halt_cnt = 0;
      op_u.press(1, 4);
      chk("halt pulses", halt_cnt, (s / 2 == 1) || s[0]);
    end
    $display("test halt key done");
    results();
  end
endmodule : test_keypad_key_display_select
